/* File: verilog/smd_decoder.v */
`include "smd_regs.vh"
`default_nettype none
// Behaviour
// - telegram is command plus seven parameter bytes
// - multi-byte values packed low byte first
// - second byte selects set/store/read action
// - reads answer with same telegram layout
// - limit code zero uses hardware select inputs
// - codes 1-3 pick current per high-current switch
// - three phase currents, 255 is full
// - current query returns three stored currents
// - store frequency pre-divider 0 to 15
// - resolution 1-64 direct, 65-67 fractional
// - signed waveform, forced sine above 64
// - seventh byte enables mixed decay
// - store acceleration and velocity 1 to 8191
// - motion query returns acc, ref vel, vel
// - position query returns signed 24-bit position
// - motion state returns vel, acc, flags
// - ramp during ramp waits for completion, only the latest one is kept
// - ramp target limited -8388608 to 16777215
// - constant rotation at signed velocity, max acc
// - position reset clears position and encoder
// - soft stop decelerates with max acceleration
// - emergency stop acts as alarm input
module smd_decoder (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // incoming telegram bytes, command byte first
  input  wire        rx_valid,
  input  wire [7:0]  rx_byte,
  // answer telegram bytes
  output reg         tx_valid,
  output reg  [7:0]  tx_byte,
  // hardware inputs
  input  wire        current_select_in0,
  input  wire        current_select_in1,
  input  wire        high_current_sw,
  // motion engine status
  input  wire        ramp_busy,
  input  wire [23:0] motor_position,
  input  wire [11:0] motor_velocity,
  input  wire [11:0] motor_accel,
  input  wire        ref_search_active,
  input  wire        auto_corr_active,
  // current and chopper settings
  output reg  [2:0]  current_limit_sel,
  output reg         use_hw_current,
  output reg  [7:0]  standby_current,
  output reg  [7:0]  active_current,
  output reg  [7:0]  accel_current,
  output reg  [3:0]  freq_prediv,
  output reg  [6:0]  ustep_code,
  output reg  [7:0]  waveform,
  output reg         mixed_decay_en,
  // ramp parameters
  output reg  [12:0] max_accel,
  output reg  [12:0] max_velocity,
  output reg  [12:0] ref_velocity,
  output reg  [12:0] bow_value,
  // motion commands
  output reg         ramp_start,
  output reg  [31:0] ramp_target,
  output reg         rotate_start,
  output reg  [13:0] rotate_velocity,
  output reg         pos_reset,
  output reg         soft_stop,
  output reg         emergency_stop
);
  localparam ST_RX   = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_TX   = 3'b100;

  reg [2:0]  state_r;
  reg [2:0]  cnt_r;
  reg [7:0]  tel_r [0:7];
  reg [7:0]  ans_r [0:7];
  reg        ans_pend_r;
  reg        nv_rd_r;
  reg        q_valid_r;
  reg [31:0] q_target_r;
  reg        ramp_busy_r;

  wire [7:0]  cmd = tel_r[0];
  wire [7:0]  act = tel_r[1];
  wire [15:0] p12 = {tel_r[3], tel_r[2]};
  wire [15:0] p34 = {tel_r[5], tel_r[4]};
  wire [31:0] p14 = {tel_r[5], tel_r[4], tel_r[3], tel_r[2]};
  wire        do_set = (act == `SMD_ACT_SET_STORE) ||
                       (act == `SMD_ACT_SET_ONLY);
  wire        do_store = (act == `SMD_ACT_SET_STORE);
  wire        rd_nv = (act == `SMD_ACT_READ_STORE);
  wire        rd_act = (act == `SMD_ACT_READ_ACT);
  wire        ok13_a = (p12[15:13] == 3'h0) && (p12[12:0] != 13'h0);
  wire        ok13_b = (p34[15:13] == 3'h0) && (p34[12:0] != 13'h0);
  wire        res_ok = (tel_r[2] != 8'h00) &&
                       (tel_r[2] <= `SMD_RES_MAX_CODE);
  wire signed [31:0] p14_s = p14;
  wire        pos_ok = (p14_s >= $signed(`SMD_POS_MIN)) &&
                       (p14_s <= $signed(`SMD_POS_MAX));
  wire        rot_ok = (p12[15:13] == 3'h0) ||
                       ((p12[15:13] == 3'h7) && (p12[12:0] != 13'h0));

  // nonvolatile image: slot per parameter command, six bytes each
  reg         nv_we;
  reg  [2:0]  nv_wa;
  reg  [2:0]  nv_ra;
  wire [55:0] nv_rd;
  wire [55:0] nv_wd = {tel_r[7], tel_r[6], tel_r[5], tel_r[4],
                       tel_r[3], tel_r[2], 8'h00};

  always @* begin
    nv_we = 1'b0;
    nv_wa = `SMD_NV_CURLIM;
    nv_ra = `SMD_NV_CURLIM;
    case (cmd)
      `SMD_CMD_CUR_CTRL,
      `SMD_CMD_GET_CUR:   nv_ra = `SMD_NV_CURCTRL;
      `SMD_CMD_FREQ_RANGE: nv_ra = `SMD_NV_FDIV;
      `SMD_CMD_ACC_VEL,
      `SMD_CMD_GET_ACCVEL: nv_ra = `SMD_NV_ACCVEL;
      `SMD_CMD_USTEP:     nv_ra = `SMD_NV_USTEP;
      `SMD_CMD_BOW:       nv_ra = `SMD_NV_BOW;
      `SMD_CMD_REF_VEL:   nv_ra = `SMD_NV_REFVEL;
      default:            nv_ra = `SMD_NV_CURLIM;
    endcase
    if (state_r == ST_EXEC && do_store) begin
      nv_wa = nv_ra;
      nv_we = (cmd == `SMD_CMD_CUR_LIMIT) || (cmd == `SMD_CMD_CUR_CTRL) ||
              (cmd == `SMD_CMD_FREQ_RANGE) || (cmd == `SMD_CMD_USTEP) ||
              (cmd == `SMD_CMD_ACC_VEL && ok13_a && ok13_b) ||
              (cmd == `SMD_CMD_BOW && ok13_a) ||
              (cmd == `SMD_CMD_REF_VEL && ok13_a);
    end
  end

  smd_nv_mem #(.AW(3), .DW(56)) u_nv (
    .mclk    (mclk),
    .wr_en   (nv_we),
    .wr_addr (nv_wa),
    .wr_data (nv_wd),
    .rd_addr (nv_ra),
    .rd_data (nv_rd)
  );

  integer i;
  always @(posedge mclk) begin
    ramp_start   <= 1'b0;
    rotate_start <= 1'b0;
    pos_reset    <= 1'b0;
    soft_stop    <= 1'b0;
    tx_valid     <= 1'b0;
    if (!rst_n) begin
      state_r <= ST_RX;
      cnt_r <= 3'h0;
      for (i = 0; i < 8; i = i + 1) begin
        tel_r[i] <= 8'h00;
        ans_r[i] <= 8'h00;
      end
      ans_pend_r <= 1'b0;
      nv_rd_r <= 1'b0;
      q_valid_r <= 1'b0;
      q_target_r <= 32'h0;
      ramp_busy_r <= 1'b0;
      tx_byte <= 8'h00;
      current_limit_sel <= {1'b0, `SMD_RST_CURLIM};
      use_hw_current <= 1'b0;
      standby_current <= `SMD_RST_CUR;
      active_current <= `SMD_RST_CUR;
      accel_current <= `SMD_RST_CUR;
      freq_prediv <= 4'h0;
      ustep_code <= `SMD_RST_RES;
      waveform <= 8'h00;
      mixed_decay_en <= 1'b0;
      max_accel <= `SMD_RST_ACC;
      max_velocity <= `SMD_RST_VEL;
      ref_velocity <= `SMD_RST_VEL;
      bow_value <= `SMD_RST_BOW;
      ramp_target <= 32'h0;
      rotate_velocity <= 14'h0;
      emergency_stop <= 1'b0;
    end else begin
      ramp_busy_r <= ramp_busy;
      // queued ramp starts once the engine drops busy
      if (q_valid_r && !ramp_busy && !ramp_start) begin
        ramp_start <= 1'b1;
        ramp_target <= q_target_r;
        q_valid_r <= 1'b0;
      end
      // hardware current select tracks the pins live
      if (use_hw_current) begin
        current_limit_sel <= {high_current_sw, current_select_in0 &
          current_select_in1 ? 2'h3 : (current_select_in0 |
          current_select_in1 ? 2'h2 : 2'h1)};
      end
      case (state_r)
        ST_RX: begin
          if (rx_valid) begin
            tel_r[cnt_r] <= rx_byte;
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == `SMD_TEL_LAST) begin
              state_r <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          // answer mirrors the received telegram layout
          for (i = 0; i < 8; i = i + 1) begin
            ans_r[i] <= tel_r[i];
          end
          ans_pend_r <= 1'b0;
          nv_rd_r <= 1'b0;
          state_r <= ST_RX;
          case (cmd)
            `SMD_CMD_CUR_LIMIT: begin
              if (do_set && tel_r[2] == 8'h00) begin
                use_hw_current <= 1'b1;
              end else if (do_set && tel_r[2] <= 8'h03) begin
                use_hw_current <= 1'b0;
                current_limit_sel <= {high_current_sw, tel_r[2][1:0]};
              end
              ans_r[2] <= use_hw_current ? 8'h00 :
                          {6'h00, current_limit_sel[1:0]};
            end
            `SMD_CMD_CUR_CTRL: begin
              if (do_set) begin
                standby_current <= tel_r[2];
                active_current <= tel_r[3];
                accel_current <= tel_r[4];
              end
              ans_r[2] <= standby_current;
              ans_r[3] <= active_current;
              ans_r[4] <= accel_current;
            end
            `SMD_CMD_GET_CUR: begin
              nv_rd_r <= 1'b1;
              ans_pend_r <= 1'b1;
            end
            `SMD_CMD_FREQ_RANGE: begin
              if (do_set && tel_r[2] <= `SMD_FDIV_MAX) begin
                freq_prediv <= tel_r[2][3:0];
              end
              ans_r[2] <= {4'h0, freq_prediv};
            end
            `SMD_CMD_USTEP: begin
              if (do_set && res_ok) begin
                ustep_code <= tel_r[2][6:0];
                waveform <= (tel_r[2] > `SMD_RES_MAX_DIRECT) ? 8'h00 :
                            tel_r[3];
                mixed_decay_en <= tel_r[6][0];
              end
              ans_r[2] <= {1'b0, ustep_code};
              ans_r[3] <= waveform;
              ans_r[6] <= {7'h00, mixed_decay_en};
            end
            `SMD_CMD_ACC_VEL: begin
              if (do_set && ok13_a && ok13_b) begin
                max_accel <= p12[12:0];
                max_velocity <= p34[12:0];
              end
              {ans_r[3], ans_r[2]} <= {3'h0, max_accel};
              {ans_r[5], ans_r[4]} <= {3'h0, max_velocity};
            end
            `SMD_CMD_BOW: begin
              if (do_set && ok13_a) begin
                bow_value <= p12[12:0];
              end
              {ans_r[3], ans_r[2]} <= {3'h0, bow_value};
            end
            `SMD_CMD_REF_VEL: begin
              if (do_set && ok13_a) begin
                ref_velocity <= p12[12:0];
              end
              {ans_r[3], ans_r[2]} <= {3'h0, ref_velocity};
            end
            `SMD_CMD_GET_ACCVEL: begin
              {ans_r[3], ans_r[2]} <= {3'h0, max_accel};
              {ans_r[5], ans_r[4]} <= {3'h0, ref_velocity};
              {ans_r[7], ans_r[6]} <= {3'h0, max_velocity};
              state_r <= ST_TX;
            end
            `SMD_CMD_GET_POS: begin
              {ans_r[5], ans_r[4], ans_r[3], ans_r[2]} <=
                {{8{motor_position[23]}}, motor_position};
              state_r <= ST_TX;
            end
            `SMD_CMD_GET_MOTION: begin
              {ans_r[3], ans_r[2]} <=
                {{4{motor_velocity[11]}}, motor_velocity};
              {ans_r[5], ans_r[4]} <= {{4{motor_accel[11]}}, motor_accel};
              ans_r[6] <= {7'h00, ref_search_active};
              ans_r[7] <= {7'h00, auto_corr_active};
              state_r <= ST_TX;
            end
            `SMD_CMD_RAMP: begin
              if (pos_ok) begin
                if (ramp_busy || q_valid_r) begin
                  q_valid_r <= 1'b1;
                  q_target_r <= p14;
                end else begin
                  ramp_start <= 1'b1;
                  ramp_target <= p14;
                end
              end
            end
            `SMD_CMD_ROTATE: begin
              if (rot_ok) begin
                rotate_start <= 1'b1;
                rotate_velocity <= p12[13:0];
                q_valid_r <= 1'b0;
              end
            end
            `SMD_CMD_POS_RESET: pos_reset <= 1'b1;
            `SMD_CMD_SOFT_STOP: begin
              soft_stop <= 1'b1;
              q_valid_r <= 1'b0;
            end
            `SMD_CMD_EMERG_STOP: begin
              emergency_stop <= 1'b1;
              q_valid_r <= 1'b0;
            end
            default: ;
          endcase
          if (rd_nv && cmd != `SMD_CMD_GET_CUR &&
              cmd != `SMD_CMD_GET_ACCVEL) begin
            nv_rd_r <= 1'b1;
            ans_pend_r <= 1'b1;
          end else if (rd_act || cmd == `SMD_CMD_GET_CUR) begin
            state_r <= ST_TX;
          end
          if (rd_nv || cmd == `SMD_CMD_GET_CUR) begin
            state_r <= ST_TX;
          end
          cnt_r <= 3'h0;
        end
        ST_TX: begin
          // stored image arrives one cycle late from the memory
          if (nv_rd_r) begin
            {ans_r[7], ans_r[6], ans_r[5], ans_r[4], ans_r[3],
             ans_r[2]} <= nv_rd[55:8];
            nv_rd_r <= 1'b0;
          end else if (ans_pend_r) begin
            ans_pend_r <= 1'b0;
          end else begin
            tx_valid <= 1'b1;
            tx_byte <= ans_r[cnt_r];
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == `SMD_TEL_LAST) begin
              state_r <= ST_RX;
            end
          end
        end
        default: state_r <= ST_RX;
      endcase
    end
  end
endmodule // smd_decoder
`default_nettype wire

/* File: verilog/smd_regs.vh */
`ifndef SMD_REGS_VH
`define SMD_REGS_VH
// command codes
`define SMD_CMD_CUR_LIMIT  8'h10
`define SMD_CMD_CUR_CTRL   8'h11
`define SMD_CMD_FREQ_RANGE 8'h12
`define SMD_CMD_ACC_VEL    8'h14
`define SMD_CMD_REF_VEL    8'h16
`define SMD_CMD_USTEP      8'h17
`define SMD_CMD_GET_POS    8'h20
`define SMD_CMD_GET_MOTION 8'h21
`define SMD_CMD_RAMP       8'h23
`define SMD_CMD_ROTATE     8'h25
`define SMD_CMD_POS_RESET  8'h27
`define SMD_CMD_SOFT_STOP  8'h2a
`define SMD_CMD_EMERG_STOP 8'h2b
`define SMD_CMD_GET_ACCVEL 8'h52
`define SMD_CMD_GET_CUR    8'h53
`define SMD_CMD_BOW        8'h63
// storage actions
`define SMD_ACT_SET_STORE  8'h00
`define SMD_ACT_SET_ONLY   8'h01
`define SMD_ACT_READ_STORE 8'h02
`define SMD_ACT_READ_ACT   8'h03
// ranges
`define SMD_MAX13          13'h1fff
`define SMD_FDIV_MAX       8'h0f
`define SMD_RES_MAX_DIRECT 8'h40
`define SMD_RES_MAX_CODE   8'h43
`define SMD_POS_MIN        32'hff800000
`define SMD_POS_MAX        32'h00ffffff
`define SMD_TEL_LAST       3'h7
// nonvolatile image slots
`define SMD_NV_CURLIM      3'h0
`define SMD_NV_CURCTRL     3'h1
`define SMD_NV_FDIV        3'h2
`define SMD_NV_ACCVEL      3'h3
`define SMD_NV_USTEP       3'h4
`define SMD_NV_BOW         3'h5
`define SMD_NV_REFVEL      3'h6
// reset values
`define SMD_RST_CURLIM     2'h3
`define SMD_RST_CUR        8'hff
`define SMD_RST_RES        7'h40
`define SMD_RST_ACC        13'h0064
`define SMD_RST_VEL        13'h03e8
`define SMD_RST_BOW        13'h0064
`endif

/* File: verilog/smd_nv_mem.v */
`default_nettype none
module smd_nv_mem #(
  parameter AW = 3,
  parameter DW = 56
) (
  // clock
  input  wire          mclk,
  // write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  // read port, registered
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  // contents undefined until first store, as a real cold image would be
  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // smd_nv_mem
`default_nettype wire

/* File: test/smd_decoder_properties.sv */
`default_nettype none
module smd_decoder_properties (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // watched outputs, plus the ramp_busy input
  input wire logic        tx_valid,
  input wire logic        ramp_busy,
  input wire logic [2:0]  current_limit_sel,
  input wire logic [6:0]  ustep_code,
  input wire logic [12:0] max_accel,
  input wire logic [12:0] max_velocity,
  input wire logic        ramp_start,
  input wire logic [31:0] ramp_target,
  input wire logic        rotate_start,
  input wire logic [13:0] rotate_velocity,
  input wire logic        emergency_stop
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_answer;
    tx_valid [*8] ##1 !tx_valid;
  endsequence
  a_answer_len: assert property ($rose(tx_valid) |-> s_answer)
    else $error("answer burst is not eight bytes");
  a_ramp_waits: assert property (ramp_start |-> !$past(ramp_busy))
    else $error("ramp started while engine busy");
  a_ramp_once: assert property (ramp_start |=> !ramp_start)
    else $error("queued ramp started twice");
  a_target_range: assert property (ramp_start |->
    $signed(ramp_target) >= -32'sd8388608 &&
    $signed(ramp_target) <= 32'sd16777215)
    else $error("ramp target out of range");
  a_rotate_range: assert property (rotate_start |->
    $signed(rotate_velocity) >= -14'sd8191 &&
    $signed(rotate_velocity) <= 14'sd8191)
    else $error("rotation velocity out of range");
  a_accvel_nonzero: assert property (max_accel != 13'h0 &&
    max_velocity != 13'h0)
    else $error("zero acceleration or velocity");
  a_ustep_range: assert property (ustep_code != 7'h0 &&
    ustep_code <= 7'h43)
    else $error("microstep code out of range");
  a_limit_code: assert property (current_limit_sel[1:0] != 2'h0)
    else $error("current limit code zero");
  a_estop_sticky: assert property (emergency_stop |=> emergency_stop)
    else $error("emergency stop released");
endmodule // smd_decoder_properties

bind smd_decoder smd_decoder_properties u_smd_decoder_properties (
  .mclk, .rst_n, .tx_valid, .ramp_busy, .current_limit_sel, .ustep_code,
  .max_accel, .max_velocity, .ramp_start, .ramp_target, .rotate_start,
  .rotate_velocity, .emergency_stop);
`default_nettype wire

/* File: test/smd_host_model.sv */
`default_nettype none
module smd_host_model (
  // clock
  input  wire logic       mclk,
  // telegram to the device
  output var  logic       rx_valid,
  output var  logic [7:0] rx_byte,
  // answer from the device
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] reply;
  int          rcnt;
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h5a;
  end
  // command first, all seven parameter bytes, never shortened
  task automatic send(input logic [63:0] tel);
    rcnt = 0;
    for (int i = 7; i >= 0; i--) begin
      @(negedge mclk);
      rx_valid = 1'b1;
      rx_byte  = tel[i*8 +: 8];
    end
    @(negedge mclk);
    rx_valid = 1'b0;
    // idle line must not look like the last byte
    rx_byte  = ~rx_byte;
  endtask
  always @(posedge mclk) begin
    if (tx_valid) begin
      reply <= {reply[55:0], tx_byte};
      rcnt  <= rcnt + 1;
    end
  end
endmodule // smd_host_model
`default_nettype wire

/* File: test/smd_decoder_bench.sv */
`default_nettype none
module smd_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_n, rx_valid, tx_valid, high_current_sw, ramp_busy;
  logic        current_select_in0, current_select_in1, ref_search_active;
  logic        auto_corr_active, use_hw_current, mixed_decay_en, pos_reset;
  logic        ramp_start, rotate_start, soft_stop, emergency_stop;
  logic [7:0]  rx_byte, tx_byte, standby_current, active_current, waveform;
  logic [7:0]  accel_current;
  logic [23:0] motor_position;
  logic [11:0] motor_velocity, motor_accel;
  logic [2:0]  current_limit_sel;
  logic [3:0]  freq_prediv;
  logic [6:0]  ustep_code;
  logic [12:0] max_accel, max_velocity, ref_velocity, bow_value;
  logic [31:0] ramp_target, tgt_seen;
  logic [13:0] rotate_velocity;
  int          error_cnt, num_checks, n_ramp, n_rot, n_pos, n_soft;

  smd_host_model u_smd_host_model (.mclk, .rx_valid, .rx_byte, .tx_valid,
    .tx_byte);
  smd_decoder u_smd_decoder (.mclk, .rst_n, .rx_valid, .rx_byte, .tx_valid,
    .tx_byte, .current_select_in0, .current_select_in1, .high_current_sw,
    .ramp_busy, .motor_position, .motor_velocity, .motor_accel,
    .ref_search_active, .auto_corr_active, .current_limit_sel,
    .use_hw_current, .standby_current, .active_current, .accel_current,
    .freq_prediv, .ustep_code, .waveform, .mixed_decay_en, .max_accel,
    .max_velocity, .ref_velocity, .bow_value, .ramp_start, .ramp_target,
    .rotate_start, .rotate_velocity, .pos_reset, .soft_stop,
    .emergency_stop);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // pulses last one cycle, so they are counted where they appear
  always @(posedge mclk) begin
    if (ramp_start) begin
      n_ramp++;
      tgt_seen <= ramp_target;
    end
    if (rotate_start) n_rot++;
    if (pos_reset) n_pos++;
    if (soft_stop) n_soft++;
  end

  task automatic chk(input string what, input logic [63:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic call(input logic [63:0] tel);
    u_smd_host_model.send(tel);
    repeat (24) @(negedge mclk);
  endtask
  task automatic ask(input logic [63:0] tel, exp);
    call(tel);
    chk("reply", exp, u_smd_host_model.reply);
    chk("reply len", 8, u_smd_host_model.rcnt);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge mclk);
    error_cnt++;
    conclude;
  end

  initial begin
    rst_n = 1'b0;
    {current_select_in0, current_select_in1, high_current_sw} = 3'h0;
    {ramp_busy, auto_corr_active} = 2'h0;
    ref_search_active = 1'b1;
    motor_position = 24'h800001;
    motor_velocity = 12'hffb;
    motor_accel = 12'h003;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk("reset lim", 3'h3, current_limit_sel);
    chk("reset cur", 24'hffffff, {standby_current, active_current,
      accel_current});
    chk("reset ramp", {13'h64, 13'h3e8, 13'h64}, {max_accel, max_velocity,
      bow_value});
    call(64'h10_00_00_00_00_00_00_00);
    current_select_in0 = 1'b1;
    repeat (3) @(negedge mclk);
    chk("hw lim", 4'ha, {use_hw_current, current_limit_sel});
    {current_select_in1, high_current_sw} = 2'h3;
    repeat (3) @(negedge mclk);
    chk("hw lim", 4'hf, {use_hw_current, current_limit_sel});
    call(64'h10_01_02_00_00_00_00_00);
    chk("sw lim", 4'h6, {use_hw_current, current_limit_sel});
    call(64'h10_01_04_00_00_00_00_00);
    chk("bad lim", 4'h6, {use_hw_current, current_limit_sel});
    call(64'h11_00_01_02_03_00_00_00);
    call(64'h11_01_04_05_06_00_00_00);
    chk("cur", 24'h040506, {standby_current, active_current,
      accel_current});
    ask(64'h53_00_00_00_00_00_00_00, 64'h53_00_01_02_03_00_00_00);
    call(64'h12_00_05_00_00_00_00_00);
    call(64'h12_01_0f_00_00_00_00_00);
    call(64'h12_01_10_00_00_00_00_00);
    chk("fdiv", 4'hf, freq_prediv);
    ask(64'h12_02_00_00_00_00_00_00, 64'h12_02_05_00_00_00_00_00);
    ask(64'h12_03_00_00_00_00_00_00, 64'h12_03_0f_00_00_00_00_00);
    for (int c = 65; c <= 67; c++) begin
      call({8'h17, 8'h01, 8'(c), 40'h7f_00_00_01_00});
      chk("ustep", {c[6:0], 8'h00, 1'b1}, {ustep_code, waveform,
        mixed_decay_en});
    end
    call(64'h17_01_40_81_00_00_00_00);
    chk("ustep", {7'h40, 8'h81, 1'b0}, {ustep_code, waveform,
      mixed_decay_en});
    call(64'h17_01_44_00_00_00_00_00);
    chk("bad ustep", 7'h40, ustep_code);
    call(64'h14_00_ff_1f_01_00_00_00);
    call(64'h14_01_00_00_05_00_00_00);
    chk("accvel", 26'h3ffe001, {max_accel, max_velocity});
    ask(64'h52_00_00_00_00_00_00_00, 64'h52_00_ff_1f_e8_03_01_00);
    call(64'h63_01_ff_1f_00_00_00_00);
    chk("bow", 13'h1fff, bow_value);
    call(64'h16_01_d0_07_00_00_00_00);
    chk("refvel", 13'h07d0, ref_velocity);
    ask(64'h20_00_00_00_00_00_00_00, 64'h20_00_01_00_80_ff_00_00);
    ask(64'h21_00_00_00_00_00_00_00, 64'h21_00_fb_ff_03_00_01_00);
    ramp_busy = 1'b1;
    call(64'h23_00_10_00_00_00_00_00);
    call(64'h23_00_00_00_00_01_00_00);
    call(64'h23_00_ff_ff_ff_00_00_00);
    chk("held", 0, n_ramp);
    ramp_busy = 1'b0;
    repeat (8) @(negedge mclk);
    chk("queued", {32'd1, 32'h00ffffff}, {n_ramp, tgt_seen});
    call(64'h23_00_00_00_80_ff_00_00);
    chk("ramp", {32'd2, 32'hff800000}, {n_ramp, tgt_seen});
    call(64'h25_00_01_e0_00_00_00_00);
    call(64'h25_00_00_e0_00_00_00_00);
    chk("rotate", {32'd1, 14'h2001}, {n_rot, rotate_velocity});
    call(64'h27_00_00_00_00_00_00_00);
    chk("pos clr", 1, n_pos);
    call(64'h2a_00_00_00_00_00_00_00);
    chk("soft", 1, n_soft);
    call(64'h2b_00_00_00_00_00_00_00);
    chk("estop", 1'b1, emergency_stop);
    conclude;
  end
endmodule // smd_decoder_bench
`default_nettype wire
